//--- hw/owd_cfg.svh
// owd_cfg.svh: addresses, field positions, reset values and counts
// for the operating watchdog; definitions only, included by bare name
`ifndef OWD_CFG_SVH
`define OWD_CFG_SVH

// cpu bus addresses
`define OWD_SERVICE_ADDR    16'hffff
`define OWD_CONFIG_ADDR     16'h001f

// system_configuration_one field positions
`define OWD_RATE_BIT        0
`define OWD_STOPDIS_BIT     1
`define OWD_DISABLE_BIT     4
`define OWD_CONFIG_RESET    8'h00

// counter geometry
`define OWD_PRE_WIDTH       12
`define OWD_CNT_WIDTH       6
`define OWD_KEEP_STAGES     4
// prescaler bits whose carry clocks the counter, per rate
`define OWD_SHORT_TAP       7
`define OWD_LONG_TAP        12

// timing counts in internal_osc_clock cycles
`define OWD_POR_CLEAR_CYC   4096
`define OWD_PIN_LOW_CYC     32

`endif

//--- hw/owd_pkg.sv
// owd_pkg: types shared by the operating watchdog modules
// assumes owd_cfg.svh supplies the numeric constants
package owd_pkg;

    // watchdog operating state
    typedef enum logic [1:0] {
        OWD_RUN,
        OWD_STOP,
        OWD_FIRE
    } owd_mode_type;

endpackage

//--- hw/owd_prescaler.sv
// owd_prescaler: prescaler with count enable, full and partial clears
// assumes one clock; clears are synchronous to sys_clk
`timescale 1ns/1ps
`include "owd_cfg.svh"

module owd_prescaler #(
    parameter int WIDTH = `OWD_PRE_WIDTH,
    parameter int KEEP  = `OWD_KEEP_STAGES
) (
    input  wire logic             sys_clk,    // internal_osc_clock
    input  wire logic             rst,        // sync reset, high
    input  wire logic             clr_all,    // clear every stage
    input  wire logic             clr_upper,  // clear stages above KEEP
    input  wire logic             run,        // count enable
    output logic [WIDTH-1:0]      count       // prescaler value
);

    // count, full clear beats the partial clear
    always_ff @(posedge sys_clk) begin
        if (rst || clr_all) begin
            count <= '0;
        end else if (clr_upper) begin
            count <= {{(WIDTH-KEEP){1'b0}}, count[KEEP-1:0]};
        end else if (run) begin
            count <= count + 1'b1;
        end
    end

endmodule // owd_prescaler

//--- hw/owd_rst_stretch.sv
// owd_rst_stretch: holds the reset pin low for a fixed cycle count
// assumes start is a one-cycle pulse; restarts while busy are ignored
`timescale 1ns/1ps
`include "owd_cfg.svh"

module owd_rst_stretch #(
    parameter int CYCLES = `OWD_PIN_LOW_CYC
) (
    input  wire logic sys_clk,   // clock
    input  wire logic rst,       // sync reset, high
    input  wire logic start,     // begin a stretched pulse
    output logic      active     // high for CYCLES cycles
);

    localparam int CW = $clog2(CYCLES + 1);

    logic [CW-1:0] left_r;       // cycles still to hold

    // load on start, count down to zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            left_r <= '0;
        end else if (start && left_r == '0) begin
            left_r <= CW'(CYCLES);
        end else if (left_r != '0) begin
            left_r <= left_r - 1'b1;
        end
    end

    assign active = (left_r != '0);

endmodule // owd_rst_stretch

//--- hw/owd_top.sv
// owd_top: operating watchdog with prescaler, counter and reset output
// assumes cpu bus strobes and mode inputs are synchronous to sys_clk
`timescale 1ns/1ps
`include "owd_cfg.svh"

module owd_top #(
    parameter int PRE_W   = `OWD_PRE_WIDTH,
    parameter int CNT_W   = `OWD_CNT_WIDTH,
    parameter int POR_CYC = `OWD_POR_CLEAR_CYC,
    parameter int PIN_CYC = `OWD_PIN_LOW_CYC
) (
    input  wire logic        sys_clk,         // internal_osc_clock
    input  wire logic        rst,             // internal reset, high
    input  wire logic        por,             // power-on reset, high
    input  wire logic [15:0] bus_addr,        // cpu address
    input  wire logic        bus_wr,          // cpu write strobe
    input  wire logic        bus_rd,          // cpu read strobe
    input  wire logic [7:0]  bus_wdata,       // cpu write data
    output logic      [7:0]  bus_rdata,       // cpu read data
    input  wire logic [7:0]  reset_vec_lo,    // reset vector low byte
    input  wire logic        vector_fetch,    // reset vector fetch
    input  wire logic        stop_exec,       // stop instruction pulse
    input  wire logic        stop_wake,       // wake from stop
    input  wire logic        wait_mode,       // cpu in wait mode
    input  wire logic        monitor_entry,   // monitor mode entered
    input  wire logic        blank_vectors,   // reset vectors erased
    input  wire logic        irq_pin_tst,     // test voltage on irq pin
    input  wire logic        rst_pin_tst,     // test voltage on rst pin
    input  wire logic        break_state,     // break interrupt active
    output logic             sys_reset_req,   // watchdog system reset
    output logic             rst_pin_out,     // reset pin output level
    output logic             rst_pin_oe,      // reset pin drive enable
    output logic             cause_watchdog,  // reset cause flag
    output logic             illegal_op_rst,  // illegal opcode reset
    output logic             stop_mode        // watchdog clock gated
);

    localparam logic [PRE_W-1:0] LONG_MASK  = '1;
    localparam logic [PRE_W-1:0] SHORT_MASK =
        PRE_W'((1 << `OWD_SHORT_TAP) - 1);
    localparam int PCW = $clog2(POR_CYC + 1);

    // decode of one cpu address against the bus
    function automatic logic hit(input logic [15:0] a,
                                 input logic [15:0] match);
        hit = (a == match);
    endfunction

    owd_pkg::owd_mode_type mode_r;        // operating state
    logic [7:0]        config_r;          // system_configuration_one
    logic [CNT_W-1:0]  cnt_r;             // watchdog counter
    logic [PRE_W-1:0]  pre;               // prescaler value
    logic [PCW-1:0]    por_cnt_r;         // cycles since power-up
    logic              por_armed_r;       // power-up clear pending
    logic              por_clr;           // one-shot power-up clear
    logic              mon_tst_r;         // monitor by test voltage
    logic              mon_blank_r;       // monitor by blank vectors
    logic              service_r;         // registered service write
    logic              cause_r;           // cause flag
    logic              illegal_r;         // illegal opcode pulse
    logic [7:0]        rdata_r;           // read data
    logic              enabled;           // watchdog allowed to run
    logic              run;               // prescaler advances
    logic [PRE_W-1:0]  tap_mask;          // prescaler bits per tick
    logic              tick;              // counter advances
    logic              overflow;          // timeout reached
    logic              fire;              // start watchdog reset
    logic              pin_low;           // stretched reset active
    logic              stop_enter;        // stop mode accepted
    logic              svc_wr;            // service write this cycle

    // service write detection
    assign svc_wr = bus_wr && hit(bus_addr, `OWD_SERVICE_ADDR);

    // service write acts on the next edge
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            service_r <= 1'b0;
        end else begin
            service_r <= svc_wr;
        end
    end

    // configuration register write
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            config_r <= `OWD_CONFIG_RESET;
        end else if (bus_wr && hit(bus_addr, `OWD_CONFIG_ADDR)) begin
            config_r <= bus_wdata;
        end
    end

    // read data, service address returns the vector byte
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (bus_rd) begin
            if (hit(bus_addr, `OWD_SERVICE_ADDR)) begin
                rdata_r <= reset_vec_lo;
            end else if (hit(bus_addr, `OWD_CONFIG_ADDR)) begin
                rdata_r <= config_r;
            end else begin
                rdata_r <= 8'h00;
            end
        end
    end

    assign bus_rdata = rdata_r;

    // power-up delay before the prescaler clear
    always_ff @(posedge sys_clk) begin
        if (por) begin
            por_cnt_r   <= '0;
            por_armed_r <= 1'b1;
        end else if (por_armed_r) begin
            por_cnt_r <= por_cnt_r + 1'b1;
            if (por_clr) begin
                por_armed_r <= 1'b0;
            end
        end
    end

    assign por_clr = por_armed_r && (por_cnt_r == PCW'(POR_CYC - 1));

    // monitor mode disable latches
    always_ff @(posedge sys_clk) begin
        if (por) begin
            mon_tst_r   <= 1'b0;
            mon_blank_r <= 1'b0;
        end else begin
            if (monitor_entry && irq_pin_tst) begin
                mon_tst_r <= 1'b1;
            end else if (!irq_pin_tst && !rst_pin_tst) begin
                mon_tst_r <= 1'b0;
            end
            if (monitor_entry && blank_vectors && !irq_pin_tst) begin
                mon_blank_r <= 1'b1;
            end
        end
    end

    // overall enable; wait mode is deliberately not a term
    assign enabled = !config_r[`OWD_DISABLE_BIT]
                  && !mon_tst_r
                  && !mon_blank_r
                  && !(break_state && rst_pin_tst);

    // stop gating
    assign stop_enter = stop_exec && !config_r[`OWD_STOPDIS_BIT];
    assign run = enabled && (mode_r == owd_pkg::OWD_RUN);

    owd_prescaler #(
        .WIDTH (PRE_W),
        .KEEP  (`OWD_KEEP_STAGES)
    ) u_pre (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .clr_all   (stop_enter || por_clr || vector_fetch
                    || fire || !enabled),
        .clr_upper (service_r),
        .run       (run),
        .count     (pre)
    );

    // counter tick on carry out of the selected stage
    assign tap_mask = config_r[`OWD_RATE_BIT] ? SHORT_MASK : LONG_MASK;
    assign tick = run && ((pre & tap_mask) == tap_mask);

    // final wrap comes 2^4 cycles early so timeout is 2^n - 2^4
    assign overflow = run && (cnt_r == '1)
        && ((pre & tap_mask) == (tap_mask & ~PRE_W'(15)));

    assign fire = overflow && !service_r;

    // watchdog counter
    always_ff @(posedge sys_clk) begin
        if (rst || service_r || fire || !enabled) begin
            cnt_r <= '0;
        end else if (tick) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    // operating state
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            mode_r <= owd_pkg::OWD_RUN;
        end else begin
            case (mode_r)
                owd_pkg::OWD_RUN: begin
                    if (fire) begin
                        mode_r <= owd_pkg::OWD_FIRE;
                    end else if (stop_enter) begin
                        mode_r <= owd_pkg::OWD_STOP;
                    end
                end
                owd_pkg::OWD_STOP: begin
                    if (stop_wake) begin
                        mode_r <= owd_pkg::OWD_RUN;
                    end
                end
                owd_pkg::OWD_FIRE: begin
                    if (!pin_low) begin
                        mode_r <= owd_pkg::OWD_RUN;
                    end
                end
                default: begin
                    mode_r <= owd_pkg::OWD_RUN;
                end
            endcase
        end
    end

    assign stop_mode = (mode_r == owd_pkg::OWD_STOP);

    // pin pulse; only power-on clears it, so rst cannot cut it short
    owd_rst_stretch #(
        .CYCLES (PIN_CYC)
    ) u_stretch (
        .sys_clk (sys_clk),
        .rst     (por),
        .start   (fire),
        .active  (pin_low)
    );

    // reset outputs; the watchdog has no interrupt request output
    assign sys_reset_req = pin_low;
    assign rst_pin_oe    = pin_low;
    assign rst_pin_out   = 1'b0;

    // cause flag, set wins over the power-on clear
    always_ff @(posedge sys_clk) begin
        if (fire) begin
            cause_r <= 1'b1;
        end else if (por) begin
            cause_r <= 1'b0;
        end
    end

    assign cause_watchdog = cause_r;

    // illegal opcode reset when stop is disabled
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            illegal_r <= 1'b0;
        end else begin
            illegal_r <= stop_exec && config_r[`OWD_STOPDIS_BIT];
        end
    end

    assign illegal_op_rst = illegal_r;

    // checks
    sequence s_fire;
        fire;
    endsequence

    sequence s_pin_hold;
        rst_pin_oe [*8];
    endsequence

    property p_pin_low;
        @(posedge sys_clk) disable iff (rst || por)
        s_fire |=> s_pin_hold ##1 s_pin_hold ##1 s_pin_hold
            ##1 s_pin_hold ##1 !rst_pin_oe;
    endproperty
    a_pin_low: assert property (p_pin_low)
        else $error("reset pin not held low for 32 cycles");

    property p_cause;
        @(posedge sys_clk) disable iff (rst)
        fire |=> cause_watchdog;
    endproperty
    a_cause: assert property (p_cause)
        else $error("cause flag not set by watchdog reset");

    property p_service;
        @(posedge sys_clk) disable iff (rst)
        svc_wr ##1 !fire |=> cnt_r == '0 && pre[PRE_W-1:4] == '0;
    endproperty
    a_service: assert property (p_service)
        else $error("service write did not clear counter");

    property p_disable;
        @(posedge sys_clk) disable iff (rst)
        !enabled |=> !sys_reset_req || $past(sys_reset_req);
    endproperty
    a_disable: assert property (p_disable)
        else $error("reset raised while watchdog disabled");

    property p_stop_clr;
        @(posedge sys_clk) disable iff (rst)
        stop_enter && mode_r == owd_pkg::OWD_RUN
            |=> pre == '0 ##1 $stable(pre) || stop_wake;
    endproperty
    a_stop_clr: assert property (p_stop_clr)
        else $error("prescaler not cleared or gated in stop");

    property p_illegal;
        @(posedge sys_clk) disable iff (rst)
        stop_exec && config_r[`OWD_STOPDIS_BIT]
            |=> illegal_op_rst && !stop_mode;
    endproperty
    a_illegal: assert property (p_illegal)
        else $error("stop not turned into illegal opcode reset");

    property p_vector;
        @(posedge sys_clk) disable iff (rst)
        vector_fetch |=> pre == '0;
    endproperty
    a_vector: assert property (p_vector)
        else $error("vector fetch did not clear prescaler");

    property p_blank;
        @(posedge sys_clk) disable iff (rst || por)
        mon_blank_r |=> mon_blank_r && !enabled;
    endproperty
    a_blank: assert property (p_blank)
        else $error("blank vector monitor disable released");

    property p_break;
        @(posedge sys_clk) disable iff (rst)
        break_state && rst_pin_tst |=> cnt_r == '0;
    endproperty
    a_break: assert property (p_break)
        else $error("watchdog counted during break with test voltage");

    property p_int_rst;
        @(posedge sys_clk)
        rst |=> cnt_r == '0 && pre == '0;
    endproperty
    a_int_rst: assert property (p_int_rst)
        else $error("internal reset did not clear watchdog");

endmodule // owd_top

//--- verif/owd_cpu_model.sv
// owd_cpu_model: cpu bus master and reset vector memory byte
// assumes owd_top samples its strobes at the rising edge of sys_clk
`timescale 1ns/1ps

module owd_cpu_model #(
    parameter logic [7:0] VEC_LO = 8'h3c   // arbitrary vector byte
) (
    input  wire logic        sys_clk,      // clock
    output logic      [15:0] bus_addr,     // cpu address
    output logic             bus_wr,       // write strobe
    output logic             bus_rd,       // read strobe
    output logic      [7:0]  bus_wdata,    // write data
    input  wire logic [7:0]  bus_rdata,    // read data
    output logic      [7:0]  reset_vec_lo  // vector memory byte
);
    // idle bus, no strobe at time zero
    initial begin
        bus_addr  = 16'h0000;
        bus_wr    = 1'b0;
        bus_rd    = 1'b0;
        bus_wdata = 8'h00;
    end

    // the vector byte sits behind the service address
    assign reset_vec_lo = VEC_LO;

    // one write cycle; software services by writing the service address
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge sys_clk);
        bus_wr    <= 1'b0;
        bus_addr  <= ~a; // released bus shows no stale value
        bus_wdata <= ~d;
    endtask

    // one read cycle; data is taken once the strobe edge has landed
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge sys_clk);
        bus_rd   <= 1'b0;
        bus_addr <= ~a;
        #1 d = bus_rdata;
    endtask
endmodule // owd_cpu_model

//--- verif/tb_operating_watchdog_timer.sv
// tb_operating_watchdog_timer: self-checking bench for owd_top
// assumes owd_cfg.svh addresses and a 16-cycle power-on clear count
`timescale 1ns/1ps
`include "owd_cfg.svh"

module tb_operating_watchdog_timer;
    logic        sys_clk, rst, por, vector_fetch, stop_exec, stop_wake;
    logic        wait_mode, monitor_entry, blank_vectors;
    logic        irq_pin_tst, rst_pin_tst, break_state;
    logic [15:0] bus_addr;
    logic        bus_wr, bus_rd;
    logic [7:0]  bus_wdata, bus_rdata, reset_vec_lo, d;
    logic        sys_reset_req, rst_pin_out, rst_pin_oe;
    logic        cause_watchdog, illegal_op_rst, stop_mode;
    int          err_count, tests_run, cyc, n;
    localparam logic [15:0] SVC = `OWD_SERVICE_ADDR;
    localparam logic [15:0] CFG = `OWD_CONFIG_ADDR;
    // selectors for the strobe inputs driven by pulse
    localparam int P_VEC  = 0;
    localparam int P_STOP = 1;
    localparam int P_WAKE = 2;
    localparam int P_MON  = 3;

    // reset pin level with its pull-up
    wire rst_pin_lvl = rst_pin_oe ? rst_pin_out : 1'b1;

    owd_top #(.POR_CYC(16)) dut (
        .sys_clk(sys_clk), .rst(rst), .por(por), .bus_addr(bus_addr),
        .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_wdata(bus_wdata),
        .bus_rdata(bus_rdata), .reset_vec_lo(reset_vec_lo),
        .vector_fetch(vector_fetch), .stop_exec(stop_exec),
        .stop_wake(stop_wake), .wait_mode(wait_mode),
        .monitor_entry(monitor_entry), .blank_vectors(blank_vectors),
        .irq_pin_tst(irq_pin_tst), .rst_pin_tst(rst_pin_tst),
        .break_state(break_state), .sys_reset_req(sys_reset_req),
        .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
        .cause_watchdog(cause_watchdog), .illegal_op_rst(illegal_op_rst),
        .stop_mode(stop_mode));

    owd_cpu_model cpu (
        .sys_clk(sys_clk), .bus_addr(bus_addr), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
        .reset_vec_lo(reset_vec_lo));

    // 100 mhz clock
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // hang guard
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 95000) begin
            err_count++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic rng(input logic [31:0] v, input int lo, input int hi);
        tests_run++;
        if ($isunknown(v) || v < lo || v > hi) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, v, lo, hi);
        end
    endtask

    // internal reset once any running pulse is over
    task automatic do_rst();
        int k;
        k = 0;
        while (sys_reset_req !== 1'b0 && k < 40) begin
            @(posedge sys_clk);
            k++;
        end
        chk(k < 40, 1'b1);
        @(posedge sys_clk) rst <= 1'b1;
        @(posedge sys_clk) rst <= 1'b0;
    endtask

    task automatic fresh(input logic [7:0] c);
        do_rst();
        cpu.wr(CFG, c);
    endtask

    task automatic wait_fire(output int m, input int lim);
        m = 0;
        while (sys_reset_req !== 1'b1 && m < lim) begin
            @(posedge sys_clk);
            #1 m++;
        end
    endtask

    // no reset request for c cycles
    task automatic nofire(input int c);
        int hit;
        hit = 0;
        repeat (c) begin
            @(posedge sys_clk);
            #1 if (sys_reset_req !== 1'b0) hit++;
        end
        chk(hit, 0);
    endtask

    task automatic pulse_chk();
        int p;
        p = 0;
        chk(rst_pin_lvl, 1'b0);
        chk(cause_watchdog, 1'b1);
        while (sys_reset_req === 1'b1 && p < 64) begin
            p++;
            @(posedge sys_clk);
            #1;
        end
        chk(p, 32);
    endtask

    // drive one strobe input picked by sel
    task automatic set_in(input int sel, input logic v);
        case (sel)
            P_VEC: vector_fetch <= v;
            P_STOP: stop_exec <= v;
            P_WAKE: stop_wake <= v;
            default: monitor_entry <= v;
        endcase
    endtask

    task automatic pulse(input int sel);
        @(posedge sys_clk) set_in(sel, 1'b1);
        @(posedge sys_clk) set_in(sel, 1'b0);
        #1;
    endtask

    task automatic t_regs();
        do_rst();
        cpu.rd(CFG, d);
        chk(d, 8'h00);
        cpu.wr(CFG, 8'h5a);
        cpu.rd(CFG, d);
        chk(d, 8'h5a);
        cpu.rd(SVC, d);
        chk(d, 8'h3c);
        cpu.rd(16'h1234, d);
        chk(d, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_short();
        fresh(8'h01);
        wait_mode <= 1'b1;
        wait_fire(n, 9000);
        rng(n, 8170, 8184);
        pulse_chk();
        wait_mode <= 1'b0;
        $display("test short timeout done");
    endtask

    task automatic t_service();
        fresh(8'h01);
        repeat (2) begin
            nofire(3000);
            cpu.wr(SVC, 8'ha5);
        end
        wait_fire(n, 9000);
        rng(n, 8155, 8184);
        $display("test service done");
    endtask

    task automatic t_vector();
        fresh(8'h01);
        nofire(8098);
        pulse(P_VEC);
        wait_fire(n, 300);
        rng(n + 8100, 8205, 8225);
        $display("test vector fetch done");
    endtask

    task automatic t_quiet(input logic [7:0] c, input string s);
        fresh(c);
        nofire(8200);
        $display("test %s done", s);
    endtask

    task automatic t_stop();
        fresh(8'h01);
        pulse(P_STOP);
        chk(stop_mode, 1'b1);
        chk(illegal_op_rst, 1'b0);
        nofire(8200);
        pulse(P_WAKE);
        chk(stop_mode, 1'b0);
        fresh(8'h03);
        pulse(P_STOP);
        chk(illegal_op_rst, 1'b1);
        chk(stop_mode, 1'b0);
        @(posedge sys_clk);
        #1 chk(illegal_op_rst, 1'b0);
        $display("test stop done");
    endtask

    task automatic t_monitor();
        fresh(8'h01);
        @(posedge sys_clk) irq_pin_tst <= 1'b1;
        pulse(P_MON);
        nofire(4000);
        @(posedge sys_clk) rst_pin_tst <= 1'b1;
        irq_pin_tst <= 1'b0;
        nofire(4200);
        @(posedge sys_clk) rst_pin_tst <= 1'b0;
        fresh(8'h01);
        @(posedge sys_clk) break_state <= 1'b1;
        rst_pin_tst <= 1'b1;
        nofire(8200);
        @(posedge sys_clk) break_state <= 1'b0;
        rst_pin_tst <= 1'b0;
        $display("test monitor and break done");
    endtask

    task automatic t_blank();
        @(posedge sys_clk) blank_vectors <= 1'b1;
        pulse(P_MON);
        fresh(8'h01);
        nofire(8200);
        @(posedge sys_clk) por <= 1'b1;
        rst <= 1'b1;
        @(posedge sys_clk) por <= 1'b0;
        rst <= 1'b0;
        blank_vectors <= 1'b0;
        cpu.wr(CFG, 8'h01);
        #1 chk(cause_watchdog, 1'b0);
        wait_fire(n, 9000);
        rng(n, 8184, 8204);
        pulse_chk();
        $display("test blank vectors done");
    endtask

    // main sequence
    initial begin
        {rst, por} = 2'b11;
        {vector_fetch, stop_exec, stop_wake, wait_mode} = 4'h0;
        {monitor_entry, blank_vectors, irq_pin_tst} = 3'h0;
        {rst_pin_tst, break_state} = 2'h0;
        err_count = 0;
        tests_run = 0;
        cyc = 0;
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        por <= 1'b0;
        t_regs();
        t_short();
        t_service();
        t_vector();
        t_quiet(8'h00, "long rate");
        t_quiet(8'h11, "disable");
        t_stop();
        t_monitor();
        t_blank();
        complete_run();
    end
endmodule // tb_operating_watchdog_timer
